// ---- pbc_ctrl.sv ----
// management-frame slave holding the basic phy control register
// assumes a station manager drives mdc well below mclk_in / 4
`timescale 1ns/1ps
module pbc_ctrl
   import pbc_pkg::*;
#(
   parameter logic [4:0] PHY_ADDR = PBC_PHY_ADDR_DEF
)(
   input  wire logic                   mclk_in,
   input  wire logic                   rst_b_in,
   input  wire logic                   mdc_in,
   input  wire logic                   mdio_in,
   output logic                        mdio_out,
   output logic                        mdio_oe_out,
   input  wire logic                   speed_strap_in,
   input  wire logic                   autoneg_enable_strap_in,
   input  wire logic                   isolate_strap_in,
   input  wire logic                   duplex_strap_in,
   input  wire logic                   an_speed_100_in,
   input  wire logic                   an_full_duplex_in,
   output logic                        soft_reset_out,
   output logic                        loopback_out,
   output logic                        autoneg_enable_out,
   output logic                        autoneg_restart_out,
   output logic                        power_down_out,
   output logic                        isolate_out,
   output logic                        col_test_out,
   output logic                        speed_100_out,
   output logic                        full_duplex_out
);

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisation
   pbc_link_if link ();

   pbc_sync u_sync (
      .mclk_in  (mclk_in),
      .rst_b_in (rst_b_in),
      .mdc_in   (mdc_in),
      .mdio_in  (mdio_in),
      .strap_in ({duplex_strap_in, isolate_strap_in,
                  autoneg_enable_strap_in, speed_strap_in}),
      .link     (link.src)
   );

   ////////////////////////////////////////////////////////////////////////////
   // frame engine state
   pbc_state_t  state_reg;
   logic [5:0]  cnt_reg;
   logic [13:0] hdr_reg;
   logic [15:0] shift_reg;
   logic        wr_go_reg;
   logic        mdio_out_reg;
   logic        mdio_oe_reg;

   // control fields
   logic [1:0]  settle_reg;
   logic        loop_reg;
   logic        speed_reg;
   logic        an_en_reg;
   logic        pdown_reg;
   logic        iso_reg;
   logic        an_rst_reg;
   logic        dup_reg;
   logic        col_reg;
   logic        eff_speed_reg;
   logic        eff_dup_reg;

   wire logic [13:0] hdr_next   = {hdr_reg[12:0], link.mdio_bit};
   wire logic [15:0] shift_next = {shift_reg[14:0], link.mdio_bit};
   wire logic [1:0]  hdr_start  = hdr_next[13:12];
   wire logic [1:0]  hdr_op     = hdr_next[11:10];
   wire logic [4:0]  hdr_phy    = hdr_next[9:5];
   wire logic        hdr_is_rd  = (hdr_reg[11:10] == PBC_OP_READ);
   wire logic        hdr_ok     = (hdr_start == PBC_START_CODE) &&
                                  (hdr_phy == PHY_ADDR) &&
                                  ((hdr_op == PBC_OP_READ) ||
                                   (hdr_op == PBC_OP_WRITE));
   wire logic        busy       = (settle_reg != 2'h0);

   // only register 0h is held here; the rest of the space reads zero
   wire logic        hit_ctrl   = (hdr_reg[4:0] == PBC_REG_BASIC_CTRL);
   wire logic [15:0] ctrl_word  = {busy, loop_reg, speed_reg, an_en_reg,
                                   pdown_reg, iso_reg, 1'b0, dup_reg,
                                   col_reg, PBC_RESERVED_VAL};
   wire logic [15:0] rd_word    = hit_ctrl ? ctrl_word
                                           : PBC_UNMAPPED_VAL;
   wire logic        ctrl_wr    = wr_go_reg && hit_ctrl && !busy;
   wire logic        wr_reset   = shift_reg[PBC_BIT_RESET];

   ////////////////////////////////////////////////////////////////////////////
   // serial frame: 32 ones, start, op, phy, reg, turnaround, 16 data bits
   always_ff @(posedge mclk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         state_reg    <= PBC_PRE;
         cnt_reg      <= 6'h00;
         hdr_reg      <= 14'h0000;
         shift_reg    <= 16'h0000;
         wr_go_reg    <= 1'b0;
         mdio_out_reg <= 1'b0;
         mdio_oe_reg  <= 1'b0;
      end else begin
         wr_go_reg <= 1'b0;
         if (link.mdc_rise) begin
            case (state_reg)
               PBC_PRE: begin
                  if (link.mdio_bit) begin
                     if (cnt_reg != PBC_PREAMBLE_LEN)
                        cnt_reg <= cnt_reg + 6'h01;
                  end else if (cnt_reg == PBC_PREAMBLE_LEN) begin
                     hdr_reg   <= hdr_next;
                     cnt_reg   <= 6'h01;
                     state_reg <= PBC_HDR;
                  end else begin
                     cnt_reg <= 6'h00;
                  end
               end
               PBC_HDR: begin
                  hdr_reg <= hdr_next;
                  cnt_reg <= cnt_reg + 6'h01;
                  if (cnt_reg == PBC_HDR_LAST) begin
                     cnt_reg   <= 6'h00;
                     state_reg <= hdr_ok ? PBC_TA : PBC_PRE;
                  end
               end
               PBC_TA: begin
                  // read: second turnaround bit is driven low by us
                  if (hdr_is_rd) begin
                     mdio_oe_reg  <= 1'b1;
                     mdio_out_reg <= 1'b0;
                     shift_reg    <= rd_word;
                     cnt_reg      <= 6'h00;
                     state_reg    <= PBC_RD;
                  end else if (cnt_reg == PBC_TA_LAST) begin
                     cnt_reg   <= 6'h00;
                     state_reg <= PBC_WR;
                  end else begin
                     cnt_reg <= cnt_reg + 6'h01;
                  end
               end
               PBC_WR: begin
                  shift_reg <= shift_next;
                  cnt_reg   <= cnt_reg + 6'h01;
                  if (cnt_reg == PBC_DATA_LAST) begin
                     wr_go_reg <= 1'b1;
                     cnt_reg   <= 6'h00;
                     state_reg <= PBC_PRE;
                  end
               end
               PBC_RD: begin
                  if (cnt_reg == PBC_DATA_BITS) begin
                     mdio_oe_reg <= 1'b0;
                     cnt_reg     <= 6'h00;
                     state_reg   <= PBC_PRE;
                  end else begin
                     mdio_out_reg <= shift_reg[15];
                     shift_reg    <= {shift_reg[14:0], 1'b0};
                     cnt_reg      <= cnt_reg + 6'h01;
                  end
               end
               default: begin
                  mdio_oe_reg <= 1'b0;
                  cnt_reg     <= 6'h00;
                  state_reg   <= PBC_PRE;
               end
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // control register; straps are loaded while settle_reg runs down, so the
   // value seen is the synchronised current pin level, never a reset input
   always_ff @(posedge mclk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         settle_reg <= PBC_STRAP_SETTLE;
         loop_reg   <= 1'b0;
         speed_reg  <= 1'b0;
         an_en_reg  <= 1'b0;
         pdown_reg  <= 1'b0;
         iso_reg    <= 1'b0;
         an_rst_reg <= 1'b0;
         dup_reg    <= 1'b0;
         col_reg    <= 1'b0;
      end else begin
         an_rst_reg <= 1'b0;
         if (busy) begin
            settle_reg <= settle_reg - 2'h1;
            loop_reg   <= 1'b0;
            pdown_reg  <= 1'b0;
            col_reg    <= 1'b0;
            speed_reg  <= link.strap[PBC_STRAP_SPEED];
            an_en_reg  <= link.strap[PBC_STRAP_AN];
            iso_reg    <= link.strap[PBC_STRAP_ISO];
            dup_reg    <= ~link.strap[PBC_STRAP_DUPLEX];
         end else if (ctrl_wr) begin
            if (wr_reset && pdown_reg) begin
               pdown_reg <= 1'b0;
            end else if (wr_reset) begin
               settle_reg <= PBC_STRAP_SETTLE;
            end else begin
               loop_reg   <= shift_reg[PBC_BIT_LOOPBACK];
               speed_reg  <= shift_reg[PBC_BIT_SPEED];
               an_en_reg  <= shift_reg[PBC_BIT_AN_EN];
               pdown_reg  <= shift_reg[PBC_BIT_PDOWN];
               iso_reg    <= shift_reg[PBC_BIT_ISOLATE];
               an_rst_reg <= shift_reg[PBC_BIT_AN_RST];
               dup_reg    <= shift_reg[PBC_BIT_DUPLEX];
               col_reg    <= shift_reg[PBC_BIT_COLTEST];
            end
         end
      end
   end

   // negotiated result wins over manual bits while negotiation is enabled
   always_ff @(posedge mclk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         eff_speed_reg <= 1'b0;
         eff_dup_reg   <= 1'b0;
      end else begin
         eff_speed_reg <= an_en_reg ? an_speed_100_in : speed_reg;
         eff_dup_reg   <= an_en_reg ? an_full_duplex_in : dup_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs
   assign mdio_out            = mdio_out_reg;
   assign mdio_oe_out         = mdio_oe_reg;
   assign soft_reset_out      = busy;
   assign loopback_out        = loop_reg;
   assign autoneg_enable_out  = an_en_reg;
   assign autoneg_restart_out = an_rst_reg;
   assign power_down_out      = pdown_reg;
   assign isolate_out         = iso_reg;
   assign col_test_out        = col_reg;
   assign speed_100_out       = eff_speed_reg;
   assign full_duplex_out     = eff_dup_reg;

endmodule // pbc_ctrl

// ---- pbc_ctrl_checker.sv ----
// assertions on the basic phy control register ports
// assumes one mclk_in domain; bound onto every pbc_ctrl
`timescale 1ns/1ps
module pbc_ctrl_checker (
   input wire logic mclk_in,
   input wire logic rst_b_in,
   input wire logic mdio_out,
   input wire logic mdio_oe_out,
   input wire logic speed_strap_in,
   input wire logic autoneg_enable_strap_in,
   input wire logic isolate_strap_in,
   input wire logic duplex_strap_in,
   input wire logic an_speed_100_in,
   input wire logic an_full_duplex_in,
   input wire logic soft_reset_out,
   input wire logic loopback_out,
   input wire logic autoneg_enable_out,
   input wire logic autoneg_restart_out,
   input wire logic power_down_out,
   input wire logic isolate_out,
   input wire logic col_test_out,
   input wire logic speed_100_out,
   input wire logic full_duplex_out
);
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!rst_b_in);
   sequence soft_run_s;
      soft_reset_out [*3] ##1 !soft_reset_out;
   endsequence
   // turnaround bit is driven low for at least three mclk cycles
   sequence ta_low_s;
      (mdio_oe_out && !mdio_out) [*3];
   endsequence
   restart_pulse_a: assert property (autoneg_restart_out |=>
      !autoneg_restart_out) else $error("restart pulse too long");
   soft_len_a: assert property ($rose(soft_reset_out) |-> soft_run_s)
      else $error("soft reset length wrong");
   pdown_exit_a: assert property ($rose(soft_reset_out) |->
      !$past(power_down_out)) else $error("reset taken in power-down");
   reset_clear_a: assert property ($rose(soft_reset_out) |=>
      !loopback_out && !power_down_out && !col_test_out)
      else $error("soft reset left bits set");
   an_speed_a: assert property ($past(autoneg_enable_out) &&
      !$past(soft_reset_out) |-> speed_100_out == $past(an_speed_100_in))
      else $error("speed not from negotiation");
   an_duplex_a: assert property ($past(autoneg_enable_out) &&
      !$past(soft_reset_out) |-> full_duplex_out == $past(an_full_duplex_in))
      else $error("duplex not from negotiation");
   strap_load_a: assert property ($fell(soft_reset_out) |=>
      isolate_out == isolate_strap_in &&
      autoneg_enable_out == autoneg_enable_strap_in)
      else $error("strap bits not loaded");
   strap_rate_a: assert property ($fell(soft_reset_out) |-> ##2
      (autoneg_enable_out || (speed_100_out == speed_strap_in &&
      full_duplex_out == !duplex_strap_in)))
      else $error("rate or duplex strap wrong");
   read_ta_a: assert property ($rose(mdio_oe_out) |-> ta_low_s)
      else $error("turnaround not driven low");
endmodule // pbc_ctrl_checker

bind pbc_ctrl pbc_ctrl_checker i_chk (.*);

// ---- pbc_link_if.sv ----
// carries synchronised management-pin and strap events between modules
// assumes producer and consumer share mclk_in
`timescale 1ns/1ps
interface pbc_link_if;
   logic       mdc_rise;
   logic       mdio_bit;
   logic [3:0] strap;

   modport src (output mdc_rise, output mdio_bit, output strap);
   modport dst (input mdc_rise, input mdio_bit, input strap);
endinterface

// ---- pbc_mac_model.sv ----
// station manager model: drives mdc and mdio frames, reads replies
// assumes mdio has a pull-up; mdc stands high between frames
`timescale 1ns/1ps
module pbc_mac_model
   import pbc_pkg::*;
(
   input  wire logic mclk_in,
   input  wire logic phy_d_in,
   input  wire logic phy_oe_in,
   output logic      mdc_out,
   output wire logic mdio_out
);
   initial mdc_out = 1'h1;
   logic mac_oe = 1'h0;
   logic mac_d  = 1'h1;
   // resolved wire level fed back to every party
   assign mdio_out = mac_oe ? mac_d : (phy_oe_in ? phy_d_in : 1'h1);
   // 8 mclk per bit: 800 ns; sample at the rising edge
   task automatic mdc_bit(input logic drv, input logic v, output logic s);
      @(posedge mclk_in);
      mdc_out <= 1'h0;
      mac_oe  <= drv;
      mac_d   <= v;
      repeat (4) @(posedge mclk_in);
      mdc_out <= 1'h1;
      s = mdio_out;
      repeat (3) @(posedge mclk_in);
   endtask
   task automatic frame(input logic [1:0] op, input logic [4:0] ra,
                        input logic [15:0] wd, output logic [15:0] rd);
      logic [13:0] hdr;
      logic [17:0] tail;
      logic        s;
      hdr  = {PBC_START_CODE, op, PBC_PHY_ADDR_DEF, ra};
      tail = {2'h2, wd};
      rd   = 16'h0000;
      for (int i = 0; i < 32; i++) mdc_bit(1'h1, 1'h1, s);
      for (int i = 13; i >= 0; i--) mdc_bit(1'h1, hdr[i], s);
      // on reads the wire is released from the turnaround on
      for (int i = 17; i >= 0; i--) begin
         mdc_bit(op == PBC_OP_WRITE, tail[i], s);
         if (i < 16) rd[i] = s;
      end
      @(posedge mclk_in);
      mac_oe <= 1'h0;
   endtask
endmodule // pbc_mac_model

// ---- pbc_pkg.sv ----
// constants, field layout and state codes of the basic phy control register
// assumes one 10 MHz clock; management frames arrive on a slow sampled mdc
// Functional notes
// - 32 management registers; 0h-Fh standard, 10h-1Fh vendor specific
// - writing one to bit 15 starts software reset; bit clears itself
// - bit 14 set selects loopback; resets to zero
// - bit 13 picks 100 or 10 Mbps; ignored while auto-negotiation enabled
// - speed bit reset value latched from rate strap pin
// - bit 12 enables negotiation, which overrides bits 13 and 8; strapped
// - in power-down, first reset write clears power-down, second resets chip
// - bit 10 isolates from the media-independent interface; strap default
// - writing one to bit 9 restarts auto-negotiation; bit clears itself
// - bit 8 full or half duplex; default is inverse of duplex strap
// - bit 7 enables collision signal test; resets to zero
package pbc_pkg;

   localparam int CLK_PERIOD_NS = 100;

   ////////////////////////////////////////////////////////////////////////////
   // register map
   localparam int         PBC_REG_COUNT      = 32;
   localparam logic [4:0] PBC_REG_BASIC_CTRL = 5'h00;

   localparam int PBC_BIT_RESET    = 15;
   localparam int PBC_BIT_LOOPBACK = 14;
   localparam int PBC_BIT_SPEED    = 13;
   localparam int PBC_BIT_AN_EN    = 12;
   localparam int PBC_BIT_PDOWN    = 11;
   localparam int PBC_BIT_ISOLATE  = 10;
   localparam int PBC_BIT_AN_RST   = 9;
   localparam int PBC_BIT_DUPLEX   = 8;
   localparam int PBC_BIT_COLTEST  = 7;

   localparam logic [6:0]  PBC_RESERVED_VAL = 7'h00;
   localparam logic [15:0] PBC_UNMAPPED_VAL = 16'h0000;

   ////////////////////////////////////////////////////////////////////////////
   // strap vector positions
   localparam int PBC_STRAP_SPEED  = 0;
   localparam int PBC_STRAP_AN     = 1;
   localparam int PBC_STRAP_ISO    = 2;
   localparam int PBC_STRAP_DUPLEX = 3;
   localparam int PBC_STRAP_W      = 4;

   // two synchroniser stages plus one, so loaded straps are settled levels
   localparam logic [1:0] PBC_STRAP_SETTLE = 2'h3;

   ////////////////////////////////////////////////////////////////////////////
   // management frame
   localparam logic [5:0] PBC_PREAMBLE_LEN = 6'h20;
   localparam logic [5:0] PBC_HDR_LAST     = 6'h0D;
   localparam logic [5:0] PBC_TA_LAST      = 6'h01;
   localparam logic [5:0] PBC_DATA_LAST    = 6'h0F;
   localparam logic [5:0] PBC_DATA_BITS    = 6'h10;
   localparam logic [1:0] PBC_START_CODE   = 2'h1;
   localparam logic [1:0] PBC_OP_READ      = 2'h2;
   localparam logic [1:0] PBC_OP_WRITE     = 2'h1;
   localparam logic [4:0] PBC_PHY_ADDR_DEF = 5'h01;

   typedef enum logic [4:0] {
      PBC_PRE = 5'h01,
      PBC_HDR = 5'h02,
      PBC_TA  = 5'h04,
      PBC_WR  = 5'h08,
      PBC_RD  = 5'h10
   } pbc_state_t;

endpackage

// ---- pbc_sync.sv ----
// two-stage synchroniser for mdc, mdio and strap pins, plus mdc rise detect
// assumes all inputs are asynchronous to mclk_in
`timescale 1ns/1ps
module pbc_sync
   import pbc_pkg::*;
(
   input  wire logic                   mclk_in,
   input  wire logic                   rst_b_in,
   input  wire logic                   mdc_in,
   input  wire logic                   mdio_in,
   input  wire logic [PBC_STRAP_W-1:0] strap_in,
   pbc_link_if.src                     link
);

   logic [5:0] meta_reg;
   logic [5:0] sync_reg;
   logic       mdc_last_reg;

   // first stage feeds only the second
   always_ff @(posedge mclk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         // mdc and mdio idle high; resetting them low would fake an mdc rise
         meta_reg     <= 6'h03;
         sync_reg     <= 6'h03;
         mdc_last_reg <= 1'b1;
      end else begin
         meta_reg     <= {strap_in, mdio_in, mdc_in};
         sync_reg     <= meta_reg;
         mdc_last_reg <= sync_reg[0];
      end
   end

   assign link.mdc_rise = sync_reg[0] & ~mdc_last_reg;
   assign link.mdio_bit = sync_reg[1];
   assign link.strap    = sync_reg[5:2];

endmodule // pbc_sync

// ---- phy_basic_control_register_test.sv ----
// frame-level tests of the basic phy control register
// assumes pbc_mac_model as station manager and the bound checker
`timescale 1ns/1ps
module phy_basic_control_register_test;
   import pbc_pkg::*;
   logic       mclk_in;
   logic       rst_b_in = 1'h0;
   logic [3:0] strap    = 4'h5;
   logic [1:0] an_res   = 2'h0;
   wire  [8:0] ctl;
   wire        mdc;
   wire        mdio;
   wire        phy_d;
   wire        phy_oe;
   int         fail_count = 0;
   int         n_compared = 0;
   int         n_pulse    = 0;
   int         p0;
   initial begin
      mclk_in = 1'h0;
      forever #50 mclk_in = ~mclk_in;
   end
   pbc_mac_model i_mac (.mclk_in(mclk_in), .phy_d_in(phy_d),
      .phy_oe_in(phy_oe), .mdc_out(mdc), .mdio_out(mdio));
   pbc_ctrl i_dut (
      .mclk_in(mclk_in), .rst_b_in(rst_b_in),
      .mdc_in(mdc), .mdio_in(mdio),
      .mdio_out(phy_d), .mdio_oe_out(phy_oe),
      .speed_strap_in(strap[0]), .autoneg_enable_strap_in(strap[1]),
      .isolate_strap_in(strap[2]), .duplex_strap_in(strap[3]),
      .an_speed_100_in(an_res[0]), .an_full_duplex_in(an_res[1]),
      .soft_reset_out(ctl[8]), .loopback_out(ctl[7]),
      .autoneg_enable_out(ctl[6]), .power_down_out(ctl[5]),
      .isolate_out(ctl[4]), .col_test_out(ctl[3]),
      .speed_100_out(ctl[2]), .full_duplex_out(ctl[1]),
      .autoneg_restart_out(ctl[0]));
   always @(posedge mclk_in) if (ctl[0] === 1'h1) n_pulse <= n_pulse + 1;
   ////////////////////////////////////////////////////////////////////////
   task automatic chk_word(input logic [15:0] got, input logic [15:0] e);
      n_compared++;
      if (got !== e) begin
         fail_count++;
         $display("[FAIL] %0t word %h expected %h", $time, got, e);
      end
   endtask
   // ctl bits: reset loop an pdown iso col speed duplex
   task automatic chk_ctl(input logic [7:0] e);
      n_compared++;
      if (ctl[8:1] !== e) begin
         fail_count++;
         $display("[FAIL] %0t outputs %h expected %h", $time, ctl[8:1], e);
      end
   endtask
   task automatic wr(input logic [4:0] ra, input logic [15:0] d);
      logic [15:0] x;
      i_mac.frame(PBC_OP_WRITE, ra, d, x);
      repeat (8) @(posedge mclk_in);
   endtask
   task automatic rd(input logic [4:0] ra, input logic [15:0] e);
      logic [15:0] x;
      i_mac.frame(PBC_OP_READ, ra, 16'h0000, x);
      chk_word(x, e);
      repeat (8) @(posedge mclk_in);
   endtask
   task automatic report_and_stop();
      $display("compared %0d mismatched %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // 13 frames of about 520 cycles each, with ample margin
   initial begin
      #2000000;
      fail_count++;
      report_and_stop();
   end
   initial begin
      repeat (16) @(posedge mclk_in);
      rst_b_in <= 1'h1;
      repeat (8) @(posedge mclk_in);
      rd(5'h00, 16'h2500);
      chk_ctl(8'h0B);
      $display("strap defaults done");
      wr(5'h00, 16'h41FF);
      rd(5'h00, 16'h4180);
      chk_ctl(8'h45);
      $display("plain fields done");
      @(posedge mclk_in);
      an_res <= 2'h2;
      p0 = n_pulse;
      wr(5'h00, 16'h3200);
      chk_word(16'(n_pulse - p0), 16'h0001);
      rd(5'h00, 16'h3000);
      chk_ctl(8'h21);
      @(posedge mclk_in);
      an_res <= 2'h1;
      repeat (2) @(posedge mclk_in);
      chk_ctl(8'h22);
      $display("negotiation done");
      wr(5'h05, 16'hFFFF);
      rd(5'h05, 16'h0000);
      rd(5'h00, 16'h3000);
      $display("unmapped done");
      wr(5'h00, 16'h4800);
      chk_ctl(8'h50);
      @(posedge mclk_in);
      strap <= 4'hA;
      wr(5'h00, 16'h8000);
      rd(5'h00, 16'h4000);
      chk_ctl(8'h40);
      wr(5'h00, 16'h8000);
      rd(5'h00, 16'h1000);
      chk_ctl(8'h22);
      $display("power-down exit done");
      report_and_stop();
   end
endmodule // phy_basic_control_register_test
